/* File: common/can_err_consts.svh */
`ifndef CAN_ERR_CONSTS_SVH
`define CAN_ERR_CONSTS_SVH
`define NUM_OBJ 6
`define A_GEN 8'h00
`define A_STAT 8'h04
`define A_EN 8'h08
`define A_SUM 8'h0C
`define A_OBJ0 8'h10
`define PASSIVE_LIM 9'h07F
`define BUSOFF_LIM 9'h0FF
`define TX_ERR_INC 9'h008
`define RUN_MAX 3'h5
`define IDLE_BITS 4'hA
`define RECOV_SEQ 7'h7F
`define CRC_POLY 15'h4599
`define HTRANS_NSEQ 2'h2
`endif

/* File: common/can_err_pkg.sv */
package can_err_pkg;
    typedef enum logic [1:0] {
        ERR_ACTIVE = 2'b00,
        ERR_PASSIVE = 2'b01,
        BUS_OFF = 2'b10
    } conf_state_t;
    typedef struct packed {
        logic bit_e;
        logic stuff_e;
        logic crc_e;
        logic form_e;
        logic ack_e;
    } err_t;
    typedef struct packed {
        logic receive_done_flag;
        logic transmit_done_flag;
        err_t err;
    } obj_stat_t;
    // Per-bit and per-frame strobes from the protocol engine, same clock
    typedef struct packed {
        logic sof;
        logic bit_strobe;
        logic tx_bit;
        logic transmitting;
        logic arb_field;
        logic ack_slot;
        logic err_frame_tx;
        logic stuff_chk;
        logic destuff_valid;
        logic destuff_bit;
        logic crc_check;
        logic [14:0] rx_crc;
        logic fixed_field;
        logic obj_match;
        logic [2:0] obj_idx;
        logic rx_ok;
        logic tx_ok;
        logic buf_full;
        logic timer_ovr;
        logic timer_handler;
        logic other_err_frame;
    } engine_t;
    typedef struct packed {
        logic hsel;
        logic [7:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } ahb_req_t;
    typedef struct packed {
        conf_state_t conf;
        logic [8:0] tec;
        logic [7:0] rec;
        logic [3:0] idle_bits;
        logic [6:0] recov_seq;
        logic rx_s1;
        logic rx_s2;
        logic run_bit;
        logic [2:0] run_len;
        logic [14:0] crc;
        err_t gflags;
        logic bus_off_irq_flag;
        logic frame_buffer_done_flag;
        logic timer_overrun_flag;
        obj_stat_t [5:0] obj;
        logic [5:0] obj_en;
        logic receive_irq_enable;
        logic transmit_irq_enable;
        logic error_irq_enable;
        logic global_irq_enable;
        logic timer_overrun_irq_enable;
        logic pend_bit;
        logic [2:0] pend_idx;
        logic pend_obj;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic irq;
        logic can_tx;
        logic tx_drive_en;
        logic active_err_frame;
        logic passive_err_frame;
        logic tx_wait;
    } state_t;
endpackage

/* File: rtl/can_error_and_interrupt_logic.sv */
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "can_err_consts.svh"
module can_error_and_interrupt_logic
    import can_err_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic can_rx,
    input wire engine_t eng,
    input wire ahb_req_t ahb,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic can_tx,
    output logic tx_drive_en,
    output logic active_err_frame,
    output logic passive_err_frame,
    output logic tx_wait,
    output logic bus_off_status,
    output logic error_passive_status,
    output logic can_irq
);
    state_t r;
    state_t next_r;

    // One CRC-15 step over a destuffed bit
    function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
        logic fb;
        fb = c[14] ^ b;
        crc_step = {c[13:0], 1'b0} ^ (fb ? `CRC_POLY : 15'h0000);
    endfunction

    // Summary bits: shared by readback and the interrupt line
    function automatic logic [5:0] summary(input state_t s);
        logic [5:0] v;
        v = 6'h00;
        for (int i = 0; i < `NUM_OBJ; i++) begin
            v[i] = s.obj_en[i] & ((s.receive_irq_enable & s.obj[i].receive_done_flag)
                | (s.transmit_irq_enable & s.obj[i].transmit_done_flag)
                | (s.error_irq_enable & (|s.obj[i].err)));
        end
        summary = v;
    endfunction

    // Register readback; unmapped addresses read zero
    function automatic logic [31:0] rd(input state_t s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == `A_GEN) begin
            v[7:0] = {s.bus_off_irq_flag, s.frame_buffer_done_flag,
                s.timer_overrun_flag, s.gflags};
        end else if (a == `A_STAT) begin
            v[1:0] = {s.conf == BUS_OFF, s.conf == ERR_PASSIVE};
            v[16:8] = s.tec;
            v[31:24] = s.rec;
        end else if (a == `A_EN) begin
            v[4:0] = {s.global_irq_enable, s.timer_overrun_irq_enable,
                s.receive_irq_enable, s.transmit_irq_enable, s.error_irq_enable};
            v[13:8] = s.obj_en;
        end else if (a == `A_SUM) begin
            v[5:0] = summary(s);
        end else if (a >= `A_OBJ0 && a < `A_OBJ0 + 8'(4 * `NUM_OBJ)) begin
            v[6:0] = s.obj[3'((a - `A_OBJ0) >> 2)];
        end
        rd = v;
    endfunction

    logic rx;
    logic bit_err;
    logic stuff_err;
    logic crc_err;
    logic form_err;
    logic ack_err;
    logic any_err;
    logic to_obj;
    logic gen_wr;
    logic [6:0] obj_set [6];
    err_t gen_set;

    // Error detection and state update
    always_comb begin
        next_r = r;
        rx = r.rx_s2;
        for (int i = 0; i < `NUM_OBJ; i++) begin
            obj_set[i] = 7'h00;
        end
        gen_set = '0;
        // Synchroniser for the bus pin
        next_r.rx_s1 = can_rx;
        next_r.rx_s2 = r.rx_s1;
        // Mismatch, except recessive-read-dominant in arbitration/ack or own error frame
        bit_err = eng.bit_strobe && r.conf != BUS_OFF && rx != eng.tx_bit
            && eng.transmitting && !eng.err_frame_tx
            && !(eng.tx_bit && (eng.arb_field || eng.ack_slot));
        // Run length of equal levels; sixth equal bit is an error
        stuff_err = 1'b0;
        if (eng.sof) begin
            next_r.run_len = 3'h0;
            next_r.run_bit = 1'b1;
        end else if (eng.bit_strobe && eng.stuff_chk) begin
            if (rx == r.run_bit) begin
                next_r.run_len = r.run_len + 3'h1;
                stuff_err = r.run_len >= `RUN_MAX;
            end else begin
                next_r.run_len = 3'h1;
                next_r.run_bit = rx;
            end
        end
        // CRC runs from start of frame over destuffed bits; checked on receive only
        if (eng.sof) begin
            next_r.crc = 15'h0000;
        end else if (eng.destuff_valid) begin
            next_r.crc = crc_step(r.crc, eng.destuff_bit);
        end
        crc_err = eng.crc_check && !eng.transmitting && r.crc != eng.rx_crc;
        // Fixed-form fields must read recessive
        form_err = eng.bit_strobe && eng.fixed_field && !rx;
        ack_err = eng.bit_strobe && eng.ack_slot && eng.transmitting && rx;
        any_err = (bit_err || stuff_err || crc_err || form_err || ack_err || r.pend_bit)
            && r.conf != BUS_OFF;
        to_obj = eng.transmitting || eng.obj_match;
        // Deferred bit error that follows a transmit form error
        next_r.pend_bit = form_err && eng.transmitting && r.conf != BUS_OFF;
        next_r.pend_idx = eng.obj_idx;
        next_r.pend_obj = to_obj;
        if (r.conf != BUS_OFF) begin
            if (to_obj && eng.obj_idx < 3'(`NUM_OBJ)) begin
                obj_set[eng.obj_idx][4:0] = {bit_err, stuff_err, crc_err, form_err, ack_err};
            end else begin
                gen_set = {bit_err, stuff_err, crc_err, form_err, ack_err};
            end
            if (r.pend_bit) begin
                if (r.pend_obj && r.pend_idx < 3'(`NUM_OBJ)) begin
                    obj_set[r.pend_idx][4] = 1'b1;
                end else begin
                    gen_set.bit_e = 1'b1;
                end
            end
            if (eng.obj_idx < 3'(`NUM_OBJ)) begin
                obj_set[eng.obj_idx][6] = eng.rx_ok;
                obj_set[eng.obj_idx][5] = eng.tx_ok;
            end
        end
        // Error frames: active or passive form, none when bus off
        next_r.active_err_frame = (any_err || eng.other_err_frame)
            && r.conf == ERR_ACTIVE;
        next_r.passive_err_frame = (any_err || eng.other_err_frame)
            && r.conf == ERR_PASSIVE;
        next_r.tx_wait = r.conf == ERR_PASSIVE;
        // Counters, several updates per frame allowed
        if (r.conf != BUS_OFF) begin
            // Deferred bit error belongs to the transmitter, not the receiver
            if ((any_err && eng.transmitting) || r.pend_bit) begin
                next_r.tec = r.tec + `TX_ERR_INC;
            end else if (eng.tx_ok && r.tec != 9'h000) begin
                next_r.tec = r.tec - 9'h001;
            end
            if (any_err && !eng.transmitting && !r.pend_bit && r.rec != 8'hFF) begin
                next_r.rec = r.rec + 8'h01;
            end else if (eng.rx_ok && r.rec != 8'h00) begin
                next_r.rec = r.rec - 8'h01;
            end
        end
        // Confinement state from counters
        next_r.bus_off_irq_flag = r.bus_off_irq_flag;
        case (r.conf)
            ERR_ACTIVE, ERR_PASSIVE: begin
                if (next_r.tec > `BUSOFF_LIM) begin
                    next_r.conf = BUS_OFF;
                    next_r.idle_bits = 4'h0;
                    next_r.recov_seq = 7'h00;
                end else if (next_r.tec > `PASSIVE_LIM
                    || {1'b0, next_r.rec} > `PASSIVE_LIM) begin
                    next_r.conf = ERR_PASSIVE;
                end else begin
                    next_r.conf = ERR_ACTIVE;
                end
            end
            BUS_OFF: begin
                // Recovery after 128 runs of 11 recessive bits
                if (eng.bit_strobe) begin
                    if (!rx) begin
                        next_r.idle_bits = 4'h0;
                    end else if (r.idle_bits == `IDLE_BITS) begin
                        next_r.idle_bits = 4'h0;
                        next_r.recov_seq = r.recov_seq + 7'h01;
                        if (r.recov_seq == `RECOV_SEQ) begin
                            next_r.conf = ERR_ACTIVE;
                            next_r.tec = 9'h000;
                            next_r.rec = 8'h00;
                        end
                    end else begin
                        next_r.idle_bits = r.idle_bits + 4'h1;
                    end
                end
            end
            default: begin
                next_r.conf = ERR_ACTIVE;
            end
        endcase
        // Bus off releases the line on the very edge it is entered
        next_r.can_tx = next_r.conf == BUS_OFF ? 1'b1 : eng.tx_bit;
        next_r.tx_drive_en = next_r.conf != BUS_OFF;
        // AHB-Lite slave: zero wait states, always OKAY
        next_r.hreadyout = 1'b1;
        next_r.dp_wr = 1'b0;
        if (ahb.hsel && ahb.hready && ahb.htrans == `HTRANS_NSEQ) begin
            next_r.dp_wr = ahb.hwrite;
            next_r.dp_addr = {ahb.haddr[7:2], 2'b00};
            next_r.hrdata = rd(r, {ahb.haddr[7:2], 2'b00});
        end
        gen_wr = r.dp_wr && r.dp_addr == `A_GEN;
        // Write-one clears; a set in the same cycle wins
        next_r.gflags = (r.gflags & ~(gen_wr ? ahb.hwdata[4:0] : 5'h00)) | gen_set;
        next_r.timer_overrun_flag = (r.timer_overrun_flag
            & ~(gen_wr & ahb.hwdata[5]) & ~eng.timer_handler) | eng.timer_ovr;
        next_r.frame_buffer_done_flag = (r.frame_buffer_done_flag
            & ~(gen_wr & ahb.hwdata[6])) | eng.buf_full;
        next_r.bus_off_irq_flag = (r.bus_off_irq_flag & ~(gen_wr & ahb.hwdata[7]))
            | (r.conf != BUS_OFF && next_r.conf == BUS_OFF);
        if (r.dp_wr && r.dp_addr == `A_EN) begin
            {next_r.global_irq_enable, next_r.timer_overrun_irq_enable,
                next_r.receive_irq_enable, next_r.transmit_irq_enable,
                next_r.error_irq_enable} = ahb.hwdata[4:0];
            next_r.obj_en = ahb.hwdata[13:8];
        end
        // Object status takes the written word, so software clears by read-modify-write
        for (int i = 0; i < `NUM_OBJ; i++) begin
            if (r.dp_wr && r.dp_addr == `A_OBJ0 + 8'(4 * i)) begin
                next_r.obj[i] = ahb.hwdata[6:0] | obj_set[i];
            end else begin
                next_r.obj[i] = r.obj[i] | obj_set[i];
            end
        end
        // One interrupt line under the global enable
        next_r.irq = next_r.global_irq_enable && ((|summary(next_r))
            || (|next_r.gflags) || next_r.frame_buffer_done_flag
            || next_r.bus_off_irq_flag
            || (next_r.timer_overrun_irq_enable && next_r.timer_overrun_flag));
    end

    // State register, frozen while the clock enable is low unless reset is asserted
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r <= '0;
            r.conf <= ERR_ACTIVE;
            r.rx_s1 <= 1'b1;
            r.rx_s2 <= 1'b1;
            r.run_bit <= 1'b1;
            r.hreadyout <= 1'b1;
            r.can_tx <= 1'b1;
            r.tx_drive_en <= 1'b1;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register, except hresp tied low to OKAY
    assign hrdata = r.hrdata;
    assign hreadyout = r.hreadyout;
    assign hresp = 1'b0;
    assign can_tx = r.can_tx;
    assign tx_drive_en = r.tx_drive_en;
    assign active_err_frame = r.active_err_frame;
    assign passive_err_frame = r.passive_err_frame;
    assign tx_wait = r.tx_wait;
    // State codes keep one flop per status bit, so no decode sits on the pins
    assign bus_off_status = r.conf[1];
    assign error_passive_status = r.conf[0];
    assign can_irq = r.irq;
endmodule
`default_nettype wire

/* File: tb/can_bus_node.sv */
`timescale 1ns/1ps
`default_nettype none
module can_bus_node (
    input wire logic node_tx,
    input wire logic dut_tx,
    input wire logic dut_en,
    output logic can_rx
);
    // Wired-AND with recessive pull-up, so a released driver reads as 1
    assign can_rx = node_tx & (dut_en ? dut_tx : 1'b1);
endmodule
`default_nettype wire

/* File: tb/can_err_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module can_err_monitor
    import can_err_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic can_rx,
    input wire engine_t eng,
    input wire logic can_tx,
    input wire logic tx_drive_en,
    input wire logic active_err_frame,
    input wire logic passive_err_frame,
    input wire logic bus_off_status,
    input wire logic error_passive_status
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic live;
    // Sampled bit that may raise an error; bus off ignores all errors
    assign live = ce && eng.bit_strobe && !bus_off_status;
    sequence s_frame;
        active_err_frame || passive_err_frame;
    endsequence
    // Level held across the synchroniser depth
    sequence s_held(v);
        (can_rx == v)[*3];
    endsequence
    property p_rst;
        @(posedge core_clk) disable iff (1'b0)
        !rst_n && ce |=> !bus_off_status && !error_passive_status && tx_drive_en;
    endproperty
    a_one_state: assert property (!(bus_off_status && error_passive_status))
        else $error("two confinement states at once");
    a_reset_active: assert property (p_rst)
        else $error("reset did not give error active");
    a_off_release: assert property (bus_off_status |-> !tx_drive_en && can_tx)
        else $error("bus off still drives");
    a_active_kind: assert property (
        active_err_frame |-> !$past(error_passive_status) && !$past(bus_off_status))
        else $error("active frame outside error active");
    a_passive_kind: assert property (passive_err_frame |-> $past(error_passive_status))
        else $error("passive frame outside error passive");
    a_off_quiet: assert property (
        bus_off_status && $past(bus_off_status) |-> !(active_err_frame || passive_err_frame))
        else $error("error frame while bus off");
    a_ack_err: assert property (s_held(1'b1) ##0 (live && eng.ack_slot && eng.transmitting) |=> s_frame)
        else $error("missing frame on recessive ack");
    a_form_err: assert property (s_held(1'b0) ##0 (live && eng.fixed_field) |=> s_frame)
        else $error("missing frame on bad fixed field");
    a_bit_err: assert property (
        $stable(can_rx)[*2] ##0 (live && eng.transmitting && !eng.err_frame_tx
        && !eng.arb_field && !eng.ack_slot && can_rx != eng.tx_bit) |=> s_frame)
        else $error("missing frame on readback mismatch");
endmodule
bind can_error_and_interrupt_logic can_err_monitor u_mon (.core_clk, .rst_n, .ce, .can_rx, .eng,
    .can_tx, .tx_drive_en, .active_err_frame, .passive_err_frame, .bus_off_status,
    .error_passive_status);
`default_nettype wire

/* File: tb/tb_can_error_and_interrupt_logic.sv */
`timescale 1ns/1ps
`default_nettype none
`include "can_err_consts.svh"
module tb_can_error_and_interrupt_logic import can_err_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic node_tx = 1'b1;
    engine_t eng = '0;
    ahb_req_t ahb_m = '0;
    ahb_req_t ahb_in;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, can_tx, tx_drive_en, active_err_frame, passive_err_frame, tx_wait;
    logic bus_off_status, error_passive_status, can_irq, can_rx, got_a, got_p;
    int mismatches = 0;
    int cmp_count = 0;
    always #4 core_clk = ~core_clk;
    // Single slave, so its hreadyout is the bus hready
    always_comb begin
        ahb_in = ahb_m;
        ahb_in.hready = hreadyout;
    end
    can_error_and_interrupt_logic DUT (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
        .can_rx(can_rx), .eng(eng), .ahb(ahb_in), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .can_tx(can_tx), .tx_drive_en(tx_drive_en),
        .active_err_frame(active_err_frame), .passive_err_frame(passive_err_frame),
        .tx_wait(tx_wait), .bus_off_status(bus_off_status),
        .error_passive_status(error_passive_status), .can_irq(can_irq));
    can_bus_node u_node (.node_tx(node_tx), .dut_tx(can_tx), .dut_en(tx_drive_en),
        .can_rx(can_rx));
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bounded wait for hready sampled high at a rising edge
    task automatic rdy;
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                end_sim();
            end
            @(posedge core_clk);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        ahb_m.hsel <= 1'b1;
        ahb_m.haddr <= a;
        ahb_m.htrans <= `HTRANS_NSEQ;
        ahb_m.hwrite <= w;
        ahb_m.hsize <= 3'h2;
        rdy();
        ahb_m.htrans <= 2'h0;
        ahb_m.hwdata <= wd;
        rdy();
        rd = hrdata;
    endtask
    // Idle engine sends recessive, so the bus stays high between frames
    function automatic engine_t idle_eng();
        idle_eng = '0;
        idle_eng.tx_bit = 1'b1;
    endfunction
    // One engine pulse, then watch a few cycles for error frame requests
    task automatic ev(input engine_t e);
        eng <= e;
        @(posedge core_clk);
        eng <= idle_eng();
        got_a = 1'b0;
        got_p = 1'b0;
        repeat (4) begin
            @(posedge core_clk);
            got_a |= active_err_frame;
            got_p |= passive_err_frame;
        end
    endtask
    task automatic set_rx(input logic v);
        node_tx <= v;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic do_reset;
        rst_n <= 1'b0;
        eng <= idle_eng();
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        node_tx <= 1'b1;
    endtask
    task automatic t_reset;
        logic [7:0] a [5] = '{`A_GEN, `A_STAT, `A_EN, `A_SUM, 8'h40};
        do_reset();
        foreach (a[i]) begin
            xfer(1'b0, a[i], 32'h0);
            chk("reg", rd, 32'h0);
        end
        chk("drive", {can_tx, tx_drive_en, bus_off_status, error_passive_status, hresp},
            5'h18);
        $display("reset test done");
    endtask
    task automatic t_stuff;
        engine_t e;
        do_reset();
        e = '0;
        e.sof = 1'b1;
        ev(e);
        set_rx(1'b0);
        e = '0;
        e.bit_strobe = 1'b1;
        e.stuff_chk = 1'b1;
        repeat (5) ev(e);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("five bits", rd, 32'h0);
        ev(e);
        chk("frame", got_a, 1'b1);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("stuff", rd, 32'h08);
        xfer(1'b0, `A_STAT, 32'h0);
        chk("rec", rd, 32'h0100_0000);
        xfer(1'b1, `A_GEN, 32'h77);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("zero keeps", rd, 32'h08);
        xfer(1'b1, `A_GEN, 32'h08);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("one clears", rd, 32'h0);
        $display("stuff test done");
    endtask
    task automatic t_obj;
        engine_t e;
        do_reset();
        xfer(1'b1, `A_EN, 32'h401);
        e = '0;
        e.bit_strobe = 1'b1;
        e.transmitting = 1'b1;
        e.ack_slot = 1'b1;
        e.tx_bit = 1'b1;
        e.obj_match = 1'b1;
        e.obj_idx = 3'h2;
        ev(e);
        chk("frame", got_a, 1'b1);
        xfer(1'b0, `A_OBJ0 + 8'h08, 32'h0);
        chk("obj ack", rd, 32'h01);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("gen", rd, 32'h0);
        xfer(1'b0, `A_SUM, 32'h0);
        chk("sum", rd, 32'h04);
        chk("irq masked", can_irq, 1'b0);
        xfer(1'b1, `A_EN, 32'h411);
        repeat (2) @(posedge core_clk);
        chk("irq", can_irq, 1'b1);
        xfer(1'b0, `A_STAT, 32'h0);
        chk("tec", rd, 32'h0000_0800);
        // Read-modify-write acknowledge
        xfer(1'b0, `A_OBJ0 + 8'h08, 32'h0);
        xfer(1'b1, `A_OBJ0 + 8'h08, rd & 32'hFFFF_FFFE);
        xfer(1'b0, `A_OBJ0 + 8'h08, 32'h0);
        chk("obj clr", rd, 32'h0);
        repeat (2) @(posedge core_clk);
        chk("irq off", can_irq, 1'b0);
        $display("object test done");
    endtask
    task automatic t_form;
        engine_t e;
        do_reset();
        set_rx(1'b0);
        e = '0;
        e.bit_strobe = 1'b1;
        e.transmitting = 1'b1;
        e.fixed_field = 1'b1;
        e.tx_bit = 1'b1;
        e.obj_match = 1'b1;
        ev(e);
        xfer(1'b0, `A_OBJ0, 32'h0);
        chk("form and bit", rd, 32'h12);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("gen", rd, 32'h0);
        // Deferred bit error counts a second transmit error
        xfer(1'b0, `A_STAT, 32'h0);
        chk("two errors", rd, 32'h0000_1000);
        $display("form test done");
    endtask
    task automatic t_crc;
        engine_t e;
        do_reset();
        e = idle_eng();
        e.sof = 1'b1;
        ev(e);
        e = idle_eng();
        e.destuff_valid = 1'b1;
        e.destuff_bit = 1'b1;
        ev(e);
        // One set bit from a cleared register leaves exactly the polynomial
        e = idle_eng();
        e.crc_check = 1'b1;
        e.rx_crc = `CRC_POLY;
        ev(e);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("crc good", rd, 32'h0);
        e.rx_crc = 15'h0000;
        e.transmitting = 1'b1;
        ev(e);
        chk("crc tx", got_a, 1'b0);
        e.transmitting = 1'b0;
        ev(e);
        chk("frame", got_a, 1'b1);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("crc bad", rd, 32'h04);
        $display("crc test done");
    endtask
    task automatic t_conf;
        engine_t e, f;
        do_reset();
        xfer(1'b1, `A_EN, 32'h10);
        e = '0;
        e.bit_strobe = 1'b1;
        e.transmitting = 1'b1;
        e.ack_slot = 1'b1;
        e.tx_bit = 1'b1;
        for (int i = 1; i <= 17; i++) begin
            ev(e);
            chk("act", got_a, i < 17);
            chk("pas", got_p, i == 17);
            chk("passive", error_passive_status, i >= 16);
        end
        xfer(1'b0, `A_STAT, 32'h0);
        chk("sts", rd, 32'h0000_8801);
        f = '0;
        f.tx_ok = 1'b1;
        ev(f);
        chk("wait", tx_wait, 1'b1);
        for (int i = 1; i <= 16; i++) begin
            ev(e);
            chk("off", bus_off_status, i == 16);
        end
        chk("release", {tx_drive_en, can_tx}, 2'h1);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("bus_off_status flag", rd, 32'h80);
        chk("irq", can_irq, 1'b1);
        ev(e);
        chk("quiet", got_a | got_p, 1'b0);
        set_rx(1'b0);
        f = '0;
        f.bit_strobe = 1'b1;
        ev(f);
        set_rx(1'b1);
        // One sample point every third cycle stands in for a bit time
        for (int i = 1; i <= 1408; i++) begin
            eng <= f;
            @(posedge core_clk);
            eng <= idle_eng();
            repeat (2) @(posedge core_clk);
            if (i >= 1407) begin
                chk("recover", bus_off_status, i == 1407);
            end
        end
        xfer(1'b0, `A_STAT, 32'h0);
        chk("counters", rd, 32'h0);
        $display("confinement test done");
    endtask
    task automatic t_timer;
        engine_t f;
        do_reset();
        xfer(1'b1, `A_EN, 32'h18);
        f = '0;
        f.timer_ovr = 1'b1;
        ev(f);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("ovr", rd, 32'h20);
        chk("irq", can_irq, 1'b1);
        f = '0;
        f.timer_handler = 1'b1;
        ev(f);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("handler", rd, 32'h0);
        f = '0;
        f.buf_full = 1'b1;
        ev(f);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("buf", rd, 32'h40);
        xfer(1'b1, `A_GEN, 32'h40);
        xfer(1'b0, `A_GEN, 32'h0);
        chk("buf clr", rd, 32'h0);
        $display("timer test done");
    endtask
    initial begin
        t_reset();
        t_stuff();
        t_obj();
        t_form();
        t_crc();
        t_conf();
        t_timer();
        end_sim();
    end
endmodule
`default_nettype wire
